// File: src/hpps_defs.vh
// hpps_defs.vh: constants for the host port pin sharing block
// assumes inclusion by bare name from design files under src/
`ifndef HPPS_DEFS_VH
`define HPPS_DEFS_VH

// host modes decoded from {host_mode_sel_hi, host_mode_sel_lo}
`define HPPS_MODE_I2C_A0    2'h0
`define HPPS_MODE_I2C_A1    2'h1
`define HPPS_MODE_SPI_SLV   2'h2
`define HPPS_MODE_SPI_MST   2'h3

// i2c slave address upper bits
`define HPPS_I2C_ADDR_HI    5'h1d

// config status field positions
`define HPPS_CFG_LO_BIT     0
`define HPPS_CFG_HI_BIT     1
`define HPPS_CFG_RESET      2'h0

// spi master clock: half period in system clocks
`define HPPS_SCK_HALF       4'h2

// eeprom read command byte
`define HPPS_EE_READ_CMD    8'h03

`endif

// File: src/hpps_fifo.v
// hpps_fifo.v: synchronous valid/ready fifo for eeprom read data
// assumes one clock domain and an active-low async reset
`timescale 1ns/1ps

module hpps_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
)(
	// clock and reset
	input  wire             i_clk_sys,
	input  wire             i_global_reset_low,
	// fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// drain side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage words
	reg [AW:0]      wr_ptr_reg;          // extra bit tells full from empty
	reg [AW:0]      rd_ptr_reg;          // read pointer
	wire            push;                // accepted write
	wire            pop;                 // accepted read
	wire [AW:0]     fill;                // words held

	assign fill        = wr_ptr_reg - rd_ptr_reg;
	assign o_in_ready  = (fill != DEPTH[AW:0]);
	assign o_out_valid = (fill != {(AW+1){1'b0}});
	assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// storage writes, no reset needed on data
	always @(posedge i_clk_sys)
	begin
		if (push)
			mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
	end

	// pointer update
	always @(posedge i_clk_sys or negedge i_global_reset_low)
	begin
		if (!i_global_reset_low)
		begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule

// File: src/hpps_top.v
// hpps_top.v: host port pin sharing, mode strap capture, spi eeprom reader
// assumes pins arrive unsynchronised; pad logic resolves enables to wires
`timescale 1ns/1ps
`include "hpps_defs.vh"

// Contract
// - sample both mode pins at reset release
// - mode-hi pin becomes miso after reset
// - spi slave drives read data on miso
// - spi master captures eeprom data on miso
// - spi master drives sclk during autoconfig
// - sda bidirectional in i2c mode
// - master sends command address on mosi
// - mode bits decode i2c/spi slave/master
// - master drives csn low, then input
// - latch pin levels into status register
module hpps_top #(
	parameter EE_BYTES = 16,  // bytes read from eeprom during autoconfig
	parameter ADDR_W   = 16   // eeprom address width
)(
	// clock and reset
	input  wire       i_clk_sys,
	input  wire       i_global_reset_low,
	// pin if0 / csn
	input  wire       i_csn_pin,
	output reg        o_csn_out,
	output reg        o_csn_oe,
	// pin if1 / miso
	input  wire       i_miso_pin,
	output reg        o_miso_out,
	output reg        o_miso_oe,
	// pin scl / sclk
	input  wire       i_sclk_pin,
	output reg        o_sclk_out,
	output reg        o_sclk_oe,
	// pin sda / mosi
	input  wire       i_mosi_pin,
	output reg        o_mosi_out,
	output reg        o_mosi_oe,
	// core side: slave read data and i2c sda pull
	input  wire [7:0] i_slv_rd_data,
	input  wire       i_i2c_sda_low,
	// core side: slave received byte
	output reg  [7:0] o_slv_rx_data,
	output reg        o_slv_rx_valid,
	// core side: eeprom data stream
	output reg  [7:0] o_ee_data,
	output reg        o_ee_valid,
	input  wire       i_ee_ready,
	// status
	output reg  [1:0] o_config_pin_status_reg,
	output reg  [1:0] o_host_mode,
	output reg  [6:0] o_i2c_addr,
	output reg        o_autocfg_busy
);

	// master sequencer states
	localparam ST_IDLE = 3'h0;
	localparam ST_CMD  = 3'h1;
	localparam ST_DATA = 3'h2;
	localparam ST_DONE = 3'h3;
	localparam ST_WAIT = 3'h4;
	localparam CMD_BITS = 8 + ADDR_W;
	localparam [7:0] RD_CMD = `HPPS_EE_READ_CMD; // sized copy so its msb can be picked

	// pin synchronisers, first stage read only by second
	reg [3:0] sync1_reg;
	reg [3:0] sync2_reg;
	reg       sclk_d_reg;   // previous synced sclk for edge detect
	wire      csn_s  = sync2_reg[0];
	wire      miso_s = sync2_reg[1];
	wire      sclk_s = sync2_reg[2];
	wire      mosi_s = sync2_reg[3];
	wire      sclk_rise = sclk_s & ~sclk_d_reg;
	wire      sclk_fall = ~sclk_s & sclk_d_reg;

	// strap capture, master sequencer and spi slave state
	reg       cap_done_reg;  // strap taken once after release
	reg [2:0] state_reg;     // sequencer state
	reg [3:0] div_reg;       // sclk half period count
	reg [5:0] bit_reg;       // bit count in phase
	reg [CMD_BITS-1:0] sh_out_reg; // command shifter
	reg [7:0] sh_in_reg;     // eeprom byte shifter
	reg [2:0] in_cnt_reg;    // bits in received byte
	reg [15:0] byte_cnt_reg; // eeprom bytes taken
	reg [7:0] slv_tx_reg;    // slave miso shifter
	reg [7:0] slv_rx_reg;    // slave mosi shifter
	reg [2:0] slv_cnt_reg;   // slave bit count

	// fifo wiring
	reg        f_in_valid;
	wire       f_in_ready;
	wire       f_out_valid;
	wire [7:0] f_out_data;

	// two-flop synchronisers on every pin input; kept out of reset so the
	// strap levels have already passed both stages when reset lets go
	always @(posedge i_clk_sys)
	begin
		sync1_reg <= {i_mosi_pin, i_sclk_pin, i_miso_pin, i_csn_pin};
		sync2_reg <= sync1_reg;
	end

	// previous synced sclk for edge detect
	always @(posedge i_clk_sys or negedge i_global_reset_low)
	begin
		if (!i_global_reset_low)
			sclk_d_reg <= 1'b1;
		else
			sclk_d_reg <= sclk_s;
	end

	// strap capture on the first edge after release; synced values, so pins
	// must be steady from two cycles before release
	always @(posedge i_clk_sys or negedge i_global_reset_low)
	begin
		if (!i_global_reset_low)
		begin
			cap_done_reg            <= 1'b0;
			o_config_pin_status_reg <= `HPPS_CFG_RESET;
			o_host_mode             <= `HPPS_MODE_I2C_A0;
			o_i2c_addr              <= 7'h00;
		end
		else if (!cap_done_reg)
		begin
			cap_done_reg <= 1'b1;
			o_config_pin_status_reg <= {miso_s, csn_s};
			o_host_mode  <= {miso_s, csn_s};
			o_i2c_addr   <= {`HPPS_I2C_ADDR_HI, 1'b0, csn_s};
		end
	end

	// spi master sequencer: read command, address zero, then data bytes
	always @(posedge i_clk_sys or negedge i_global_reset_low)
	begin
		if (!i_global_reset_low)
		begin
			state_reg      <= ST_IDLE;
			div_reg        <= 4'h0;
			bit_reg        <= 6'h00;
			sh_out_reg     <= {CMD_BITS{1'b0}};
			sh_in_reg      <= 8'h00;
			in_cnt_reg     <= 3'h0;
			byte_cnt_reg   <= 16'h0000;
			f_in_valid     <= 1'b0;
			o_autocfg_busy <= 1'b0;
			o_sclk_out     <= 1'b0;
			o_mosi_out     <= 1'b0;
			o_csn_out      <= 1'b1;
		end
		else
		begin
			if (f_in_valid && f_in_ready)
				f_in_valid <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					o_sclk_out <= 1'b0;
					if (cap_done_reg && o_host_mode == `HPPS_MODE_SPI_MST)
					begin
						state_reg      <= ST_CMD;
						o_autocfg_busy <= 1'b1;
						o_csn_out      <= 1'b0;
						sh_out_reg     <= {`HPPS_EE_READ_CMD, {ADDR_W{1'b0}}};
						o_mosi_out     <= RD_CMD[7];
						bit_reg        <= 6'h00;
						div_reg        <= 4'h0;
					end
				end
				ST_CMD, ST_DATA:
				begin
					// stall clock while a formed byte waits for room in the full fifo
					if (!(f_in_valid && !f_in_ready))
					begin
						if (div_reg == `HPPS_SCK_HALF - 4'h1)
						begin
							div_reg    <= 4'h0;
							o_sclk_out <= ~o_sclk_out;
							// sample as sclk falls: the synced miso lags the pin by two
							// clocks, so at the rising toggle it would still show the
							// previous bit at this clock ratio
							if (o_sclk_out && state_reg == ST_DATA)
							begin
								sh_in_reg  <= {sh_in_reg[6:0], miso_s};
								in_cnt_reg <= in_cnt_reg + 3'h1;
								if (in_cnt_reg == 3'h7)
								begin
									f_in_valid   <= 1'b1;
									byte_cnt_reg <= byte_cnt_reg + 16'h0001;
									if (byte_cnt_reg == EE_BYTES[15:0] - 16'h0001)
										state_reg <= ST_DONE;
								end
							end
							else if (o_sclk_out && state_reg == ST_CMD)
							begin
								sh_out_reg <= {sh_out_reg[CMD_BITS-2:0], 1'b0};
								o_mosi_out <= sh_out_reg[CMD_BITS-2];
								bit_reg    <= bit_reg + 6'h01;
								if (bit_reg == CMD_BITS[5:0] - 6'h01)
									state_reg <= ST_DATA;
							end
						end
						else
							div_reg <= div_reg + 4'h1;
					end
				end
				ST_DONE:
				begin
					o_sclk_out <= 1'b0;
					o_csn_out  <= 1'b1;
					state_reg  <= ST_WAIT;
				end
				ST_WAIT:
				begin
					o_autocfg_busy <= 1'b0; // hand over to spi slave
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// fifo input data, byte formed with the final sampled bit
	wire [7:0] f_in_data = sh_in_reg;

	hpps_fifo #(
		.WIDTH (8),
		.DEPTH (16),
		.AW    (4)
	) u_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_global_reset_low      (i_global_reset_low),
		.i_in_valid  (f_in_valid),
		.o_in_ready  (f_in_ready),
		.i_in_data   (f_in_data),
		.o_out_valid (f_out_valid),
		.i_out_ready (i_ee_ready & ~o_ee_valid),
		.o_out_data  (f_out_data)
	);

	// output stage so eeprom stream comes from flops
	always @(posedge i_clk_sys or negedge i_global_reset_low)
	begin
		if (!i_global_reset_low)
		begin
			o_ee_valid <= 1'b0;
			o_ee_data  <= 8'h00;
		end
		else if (f_out_valid && i_ee_ready && !o_ee_valid)
		begin
			o_ee_valid <= 1'b1;
			o_ee_data  <= f_out_data;
		end
		else
			o_ee_valid <= 1'b0;
	end

	// spi slave, mode 0: sample mosi on rise, shift miso on fall
	wire slv_mode = cap_done_reg && !o_autocfg_busy && o_host_mode[1] &&
		state_reg != ST_CMD && state_reg != ST_DATA && state_reg != ST_IDLE ||
		cap_done_reg && o_host_mode == `HPPS_MODE_SPI_SLV;
	always @(posedge i_clk_sys or negedge i_global_reset_low)
	begin
		if (!i_global_reset_low)
		begin
			slv_rx_reg     <= 8'h00;
			slv_tx_reg     <= 8'h00;
			slv_cnt_reg    <= 3'h0;
			o_slv_rx_data  <= 8'h00;
			o_slv_rx_valid <= 1'b0;
			o_miso_out     <= 1'b0;
		end
		else
		begin
			o_slv_rx_valid <= 1'b0;
			if (!slv_mode || csn_s)
			begin
				slv_cnt_reg <= 3'h0;
				slv_tx_reg  <= i_slv_rd_data;
				o_miso_out  <= i_slv_rd_data[7];
			end
			else if (sclk_rise)
			begin
				slv_rx_reg  <= {slv_rx_reg[6:0], mosi_s};
				slv_cnt_reg <= slv_cnt_reg + 3'h1;
				if (slv_cnt_reg == 3'h7)
				begin
					o_slv_rx_data  <= {slv_rx_reg[6:0], mosi_s};
					o_slv_rx_valid <= 1'b1;
				end
			end
			else if (sclk_fall)
			begin
				if (slv_cnt_reg == 3'h0)
					slv_tx_reg <= i_slv_rd_data;
				else
					slv_tx_reg <= {slv_tx_reg[6:0], 1'b0};
				o_miso_out <= (slv_cnt_reg == 3'h0) ? i_slv_rd_data[7] : slv_tx_reg[6];
			end
		end
	end

	// pin enables; sclk and scl come from outside in slave modes
	always @(posedge i_clk_sys or negedge i_global_reset_low)
	begin
		if (!i_global_reset_low)
		begin
			o_csn_oe  <= 1'b0;
			o_miso_oe <= 1'b0;
			o_sclk_oe <= 1'b0;
			o_mosi_oe <= 1'b0;
		end
		else
		begin
			o_csn_oe  <= o_autocfg_busy;
			o_sclk_oe <= o_autocfg_busy;
			o_miso_oe <= slv_mode & ~csn_s;
			if (o_autocfg_busy)
				o_mosi_oe <= 1'b1;
			else
				o_mosi_oe <= cap_done_reg & ~o_host_mode[1] & i_i2c_sda_low;
		end
	end

endmodule

// File: sim/hpps_monitor.sv
// hpps_monitor.sv: port assertions for hpps_top
// assumes a bind from the bench top, one clock domain
`timescale 1ns/1ps
module hpps_monitor (
	input wire logic       i_clk_sys,
	input wire logic       i_global_reset_low,
	input wire logic       i_i2c_sda_low,
	input wire logic       o_csn_out,
	input wire logic       o_csn_oe,
	input wire logic       o_miso_oe,
	input wire logic       o_sclk_oe,
	input wire logic       o_mosi_out,
	input wire logic       o_mosi_oe,
	input wire logic [1:0] o_config_pin_status_reg,
	input wire logic [1:0] o_host_mode,
	input wire logic [6:0] o_i2c_addr,
	input wire logic       o_autocfg_busy
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_global_reset_low);
	// autocfg start: select first, then the drivers
	sequence s_start; $rose(o_autocfg_busy); endsequence
	sequence s_drive; o_csn_oe && o_sclk_oe && o_mosi_oe; endsequence
	start_order_a: assert property (s_start |-> !o_csn_out ##1 s_drive)
		else $error("autocfg start order wrong");
	csn_drive_a: assert property (o_csn_oe |-> o_host_mode == 2'h3)
		else $error("csn driven outside master mode");
	sclk_drive_a: assert property (o_sclk_oe |-> o_autocfg_busy || $past(o_autocfg_busy))
		else $error("sclk driven outside autocfg");
	miso_drive_a: assert property (o_miso_oe |-> o_host_mode[1] && !o_autocfg_busy)
		else $error("miso driven outside slave mode");
	sda_open_a: assert property (!o_host_mode[1] |-> !o_mosi_out)
		else $error("sda driven high");
	sda_follow_a: assert property (!o_host_mode[1] && $past(i_global_reset_low)
		|-> o_mosi_oe == $past(i_i2c_sda_low))
		else $error("sda pull late or lost");
	addr_map_a: assert property (!o_host_mode[1] && $past(i_global_reset_low)
		|-> o_i2c_addr == {5'h1d, 1'b0, o_host_mode[0]})
		else $error("i2c address wrong");
	status_mode_a: assert property (o_config_pin_status_reg == o_host_mode)
		else $error("status and mode differ");
	status_hold_a: assert property ($past(i_global_reset_low, 2) |-> $stable(o_config_pin_status_reg))
		else $error("status changed after capture");
endmodule

// File: sim/hpps_ee_model.sv
// hpps_ee_model.sv: serial eeprom answering one read, spi mode 0
// assumes pull-up on miso, data byte k reads as 5a xor k
`timescale 1ns/1ps
module hpps_ee_model (
	input  wire logic i_csn,
	input  wire logic i_sclk,
	input  wire logic i_mosi,
	output logic      o_miso,
	output logic [7:0] o_cmd,
	output int        o_rises
);
	int idx;
	initial o_miso = 1'b1;
	initial o_rises = 0;
	always @(negedge i_csn) o_rises = 0;
	// command shifted in msb first on rising clock
	always @(posedge i_sclk)
	begin
		if (!i_csn && o_rises < 8)
			o_cmd = {o_cmd[6:0], i_mosi};
		if (!i_csn)
			o_rises = o_rises + 1;
	end
	// data after command and address, changed on falling clock
	always @(negedge i_sclk)
	begin
		idx = o_rises - 24;
		if (!i_csn && o_rises >= 24)
			o_miso = ((8'h5a ^ idx[10:3]) >> (7 - idx[2:0])) & 1'b1;
	end
	// deselected line floats up to its pull-up
	always @(posedge i_csn) o_miso = 1'b1;
endmodule

// File: sim/hpps_top_test.sv
// hpps_top_test.sv: bench for the host port pin sharing block
// assumes pads resolve enables; host and eeprom share the spi wires
`timescale 1ns/1ps
module hpps_top_test;
	logic clk = 0, global_reset_low = 0, strap_on = 1, sda_low = 0, ee_ready = 0;
	logic h_csn = 1, h_sclk = 0, h_mosi = 1;
	logic [1:0] strap = 0;
	logic [7:0] rx_got = 0, got;
	wire [1:0] status, mode;
	wire [6:0] addr;
	wire [7:0] rx_d, ee_d, cmd;
	wire c_o, c_e, m_o, m_e, s_o, s_e, d_o, d_e, rx_v, ee_v, busy, ee_miso;
	int rises, n_ee = 0, cyc = 0, compares = 0, miscompares = 0;
	// pin levels: device enable wins, straps only around reset
	wire csn_w = c_e ? c_o : (strap_on ? strap[0] : h_csn);
	wire miso_w = m_e ? m_o : (strap_on ? strap[1] : ee_miso);
	wire sclk_w = s_e ? s_o : h_sclk;
	wire mosi_w = d_e ? d_o : h_mosi;
	always #20 clk = ~clk;
	hpps_top #(.EE_BYTES(20), .ADDR_W(16)) u_hpps_top (.i_clk_sys(clk), .i_global_reset_low(global_reset_low),
		.i_csn_pin(csn_w), .o_csn_out(c_o), .o_csn_oe(c_e), .i_miso_pin(miso_w),
		.o_miso_out(m_o), .o_miso_oe(m_e), .i_sclk_pin(sclk_w), .o_sclk_out(s_o),
		.o_sclk_oe(s_e), .i_mosi_pin(mosi_w), .o_mosi_out(d_o), .o_mosi_oe(d_e),
		.i_slv_rd_data(8'h3c), .i_i2c_sda_low(sda_low), .o_slv_rx_data(rx_d),
		.o_slv_rx_valid(rx_v), .o_ee_data(ee_d), .o_ee_valid(ee_v),
		.i_ee_ready(ee_ready), .o_config_pin_status_reg(status),
		.o_host_mode(mode), .o_i2c_addr(addr), .o_autocfg_busy(busy));
	hpps_ee_model u_hpps_ee_model (.i_csn(csn_w), .i_sclk(sclk_w), .i_mosi(mosi_w),
		.o_miso(ee_miso), .o_cmd(cmd), .o_rises(rises));
	task chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// received bytes and eeprom stream
	always @(posedge clk)
	begin
		if (rx_v === 1'b1)
			rx_got <= rx_d;
		if (ee_v === 1'b1)
		begin
			chk(ee_d, 8'h5a ^ n_ee[7:0]);
			n_ee++;
		end
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			conclude();
		end
	end
	task boot(input logic [1:0] m);
		global_reset_low <= 0;
		strap <= m;
		strap_on <= 1;
		tick(5);
		global_reset_low <= 1;
		tick(4);
		strap_on <= 0;
		tick(1);
		chk(status, m);
		chk(mode, m);
	endtask
	task t_i2c(input logic [1:0] m);
		boot(m);
		chk(addr, {5'h1d, 1'b0, m[0]});
		chk({s_e, m_e, c_e}, 0);
		sda_low <= 1;
		tick(3);
		chk({d_e, d_o}, 2'b10);
		sda_low <= 0;
		tick(3);
		chk(d_e, 0);
	endtask
	task t_slave;
		boot(2);
		h_csn <= 0;
		tick(8);
		for (int i = 7; i >= 0; i--)
		begin
			h_mosi <= 8'hc5 >> i;
			tick(4);
			got[i] = miso_w;
			h_sclk <= 1;
			tick(4);
			h_sclk <= 0;
		end
		tick(8);
		chk(rx_got, 8'hc5);
		chk(got, 8'h3c);
		h_csn <= 1;
		tick(6);
		chk({m_e, s_e}, 0);
	endtask
	task t_master;
		boot(3);
		tick(1000);
		chk({busy, n_ee[7:0]}, 16'h0100); // stalled while fifo full
		ee_ready <= 1;
		for (int k = 0; k < 2000 && busy !== 1'b0; k++)
			tick(1);
		tick(40);
		chk(n_ee, 20);
		chk(cmd, 8'h03);
		chk(rises, 24 + 20 * 8);
		chk({c_e, s_e, d_e}, 0);
	endtask
	initial
	begin
		t_i2c(0);
		t_i2c(1);
		t_slave();
		t_master();
		conclude();
	end
endmodule
bind hpps_top hpps_monitor u_hpps_monitor (.*);
